// File: rtl/etl_consts.svh
// constants for the exposure trigger and line control block
`ifndef ETL_CONSTS_SVH
`define ETL_CONSTS_SVH
`define ETL_NLINES 2
`define ETL_A_CTRL 6'h00
`define ETL_A_SETTLE 6'h04
`define ETL_A_HOLD 6'h08
`define ETL_A_EXP 6'h0C
`define ETL_A_PER 6'h10
`define ETL_A_RO 6'h14
`define ETL_A_BURST 6'h18
`define ETL_A_LSEL 6'h1C
`define ETL_A_STAT 6'h20
`define ETL_A_SWTRIG 6'h24
`define ETL_F_TEN 0
`define ETL_F_ORG 1
`define ETL_F_ACT 3
`define ETL_F_POL 6
`define ETL_F_XPW 8
`define ETL_F_BURST 9
`define ETL_F_FLIP 10
`define ETL_F_VAR 12
`define ETL_ORG_CC1 2'h0
`define ETL_ORG_SW 2'h1
`define ETL_ORG_TMR 2'h2
`define ETL_ORG_CNT 2'h3
`define ETL_ACT_RISE 3'h0
`define ETL_ACT_FALL 3'h1
`define ETL_ACT_ANY 3'h2
`define ETL_ACT_HIGH 3'h3
`define ETL_ACT_LOW 3'h4
`define ETL_POL_OFF 2'h0
`define ETL_RST_CTRL 13'h0000
`define ETL_RST_SETTLE 16'h0028
`define ETL_RST_HOLD 21'h0_0000
`define ETL_RST_EXP 24'h00_0FA0
`define ETL_RST_PER 24'h00_9C40
`define ETL_RST_RO 24'h00_1F40
`define ETL_RST_BURST 16'h0001
`define ETL_CLK_NS 25
`define ETL_US_NS 1000
`define ETL_CYC_US (`ETL_US_NS / `ETL_CLK_NS)
`define ETL_LAT_NS 3230
`define ETL_LAT_CYC ((`ETL_LAT_NS + `ETL_CLK_NS - 1) / `ETL_CLK_NS)
`define ETL_GAP_NS 62000
`define ETL_GAP_CYC ((`ETL_GAP_NS + `ETL_CLK_NS - 1) / `ETL_CLK_NS)
`define ETL_HOLD_MAX 2000000
`endif

// File: rtl/etl_pkg.sv
// types for the exposure trigger and line control block
package etl_pkg;
  typedef enum logic [1:0] {
    ETL_IDLE,
    ETL_HOLD,
    ETL_WAIT,
    ETL_EXPOSE
  } etl_state_t;
endpackage : etl_pkg

// File: rtl/etl_trigger_ctrl.sv
// exposure trigger qualification, line conditioning and frame timing
`timescale 1ns/1ps
`include "etl_consts.svh"
// Operation
// RULE1 - selected line level reads low false, high true
// RULE2 - all line levels in one word, line1 lowest
// RULE3 - polarity flip inverts line before use
// RULE4 - edge recognised only after settle interval
// RULE5 - line direction reported read only
// RULE6 - burst start yields at most limit frames
// RULE7 - triggering off runs from internal timers
// RULE8 - triggering on starts only from chosen origin
// RULE9 - frame grabber drives cc1 trigger pulses
// RULE10 - software command gives one trigger
// RULE11 - timer or counter done may trigger
// RULE12 - overlap off discards triggers during frame
// RULE13 - exposure waits minimum trigger latency; the code waits it only with the variant bit set
// RULE14 - readout overlap accepts from readout start
// RULE15 - overlap variant waits readout end plus gap
// RULE16 - short exposure delayed to end with readout
// RULE17 - next readout starts right at readout end
// RULE18 - pulse exposure extended until readout completes
// RULE19 - edge or level activation after inversion
// RULE20 - accepted trigger delayed by hold off microseconds
// RULE21 - pulse exposure spans active to opposite edge
// RULE22 - overlap off pulse trigger discarded entirely
module etl_trigger_ctrl (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [5:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [1:0] cc_line_i,
  input wire logic timer_one_done_event_i,
  input wire logic counter_one_done_event_i,
  output logic exposure_o,
  output logic readout_o,
  output logic trig_reject_o
);
  localparam int NL = `ETL_NLINES;

  logic [12:0] ctrl;
  logic [15:0] settle;
  logic [20:0] hold;
  logic [23:0] exp_len;
  logic [23:0] per_len;
  logic [23:0] ro_len;
  logic [15:0] burst_lim;
  logic lsel;
  logic sw_trig;
  logic [NL-1:0] sync_l;
  logic [NL-1:0] stable_l;
  logic cc1_q;
  logic [23:0] per_cnt;
  logic [15:0] burst_left;
  etl_pkg::etl_state_t state;
  logic [20:0] hold_left;
  logic [5:0] pre;
  logic [11:0] wcnt;
  logic seen_ro;
  logic [23:0] exp_left;
  logic [23:0] ro_left;
  logic [31:0] rd_mux;

  // register decode
  wire wr_ctrl = wr_i && (addr_i == `ETL_A_CTRL);
  wire wr_settle = wr_i && (addr_i == `ETL_A_SETTLE);
  wire wr_hold = wr_i && (addr_i == `ETL_A_HOLD);
  wire wr_exp = wr_i && (addr_i == `ETL_A_EXP);
  wire wr_per = wr_i && (addr_i == `ETL_A_PER);
  wire wr_ro = wr_i && (addr_i == `ETL_A_RO);
  wire wr_burst = wr_i && (addr_i == `ETL_A_BURST);
  wire wr_lsel = wr_i && (addr_i == `ETL_A_LSEL);
  wire wr_sw = wr_i && (addr_i == `ETL_A_SWTRIG);

  // an out of range hold off delay clamps to the longest allowed
  wire hold_big = wdata_i > 32'(`ETL_HOLD_MAX);
  wire [20:0] hold_w = hold_big ? 21'(`ETL_HOLD_MAX) : wdata_i[20:0];

  // control fields
  wire ten = ctrl[`ETL_F_TEN];
  wire [1:0] org = ctrl[`ETL_F_ORG +: 2];
  wire [2:0] act = ctrl[`ETL_F_ACT +: 3];
  wire [1:0] pol = ctrl[`ETL_F_POL +: 2];
  wire bm = ctrl[`ETL_F_BURST];
  wire [1:0] flip = ctrl[`ETL_F_FLIP +: 2];
  wire var_s = ctrl[`ETL_F_VAR];
  wire pol_off = pol == `ETL_POL_OFF;
  wire xpw = ctrl[`ETL_F_XPW] && ten && (org == `ETL_ORG_CC1);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ctrl <= `ETL_RST_CTRL;
      settle <= `ETL_RST_SETTLE;
      hold <= `ETL_RST_HOLD;
      exp_len <= `ETL_RST_EXP;
      per_len <= `ETL_RST_PER;
      ro_len <= `ETL_RST_RO;
      burst_lim <= `ETL_RST_BURST;
      lsel <= 1'b0;
      sw_trig <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl <= wdata_i[12:0];
      if (wr_settle) settle <= wdata_i[15:0];
      if (wr_hold) hold <= hold_w; // RULE20
      if (wr_exp) exp_len <= wdata_i[23:0];
      if (wr_per) per_len <= wdata_i[23:0];
      if (wr_ro) ro_len <= wdata_i[23:0];
      if (wr_burst) burst_lim <= wdata_i[15:0];
      if (wr_lsel) lsel <= wdata_i[0];
      sw_trig <= wr_sw && wdata_i[0]; // RULE10
    end
  end

  // per line synchroniser and settle filter
  genvar g;
  for (g = 0; g < NL; g++) begin : g_line
    logic s1;
    logic s2;
    logic st;
    logic [15:0] cnt;
    always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        st <= 1'b0;
        cnt <= 16'h0000;
      end else begin
        s1 <= cc_line_i[g];
        s2 <= s1;
        if (s2 == st) begin
          cnt <= 16'h0000;
        end else if (cnt >= settle) begin
          st <= s2; // RULE4
          cnt <= 16'h0000;
        end else begin
          cnt <= cnt + 16'h0001;
        end
      end
    end
    assign sync_l[g] = s2;
    assign stable_l[g] = st;
  end

  // levels after polarity flip
  wire [NL-1:0] lvl_now = sync_l ^ flip; // RULE3
  wire [NL-1:0] lvl_db = stable_l ^ flip; // RULE3
  wire cc1 = lvl_db[0];
  wire rise = cc1 && !cc1_q;
  wire fall = !cc1 && cc1_q;
  wire is_rise = act == `ETL_ACT_RISE;
  wire is_fall = act == `ETL_ACT_FALL;
  wire is_any = act == `ETL_ACT_ANY;
  wire is_high = act == `ETL_ACT_HIGH;
  wire is_low = act == `ETL_ACT_LOW;
  wire cc_evt = (is_rise && rise) || (is_fall && fall) ||
    (is_any && (rise || fall)) || (is_high && cc1) ||
    (is_low && !cc1); // RULE19
  wire pulse_lvl = (is_fall || is_low) ? !cc1 : cc1; // RULE21

  // origin select; cc1 pulses come from the frame grabber
  wire src_evt = (org == `ETL_ORG_CC1) ? cc_evt : // RULE9
    (org == `ETL_ORG_SW) ? sw_trig : // RULE10
    (org == `ETL_ORG_TMR) ? timer_one_done_event_i : // RULE11
    counter_one_done_event_i; // RULE11
  wire per_tick = !ten && (per_cnt == 24'h00_0000);
  wire raw_trig = ten ? src_evt : per_tick; // RULE7 RULE8

  // acceptance window
  wire ro_act = ro_left != 24'h00_0000;
  wire ready = (state == etl_pkg::ETL_IDLE) &&
    (pol_off ? !ro_act : 1'b1); // RULE12 RULE14 RULE22
  wire trig_ok = raw_trig && ready && (burst_left == 16'h0000);
  wire burst_go = bm && (burst_left != 16'h0000) && ready;
  wire go = bm ? burst_go : trig_ok; // RULE6

  // exposure start conditions
  wire [11:0] need = seen_ro ? 12'(`ETL_GAP_CYC) : 12'(`ETL_LAT_CYC);
  wire start_var = !ro_act && (wcnt >= need); // RULE13 RULE15
  wire [24:0] exp_p1 = {1'b0, exp_len} + 25'h000_0001;
  wire align_ok = {1'b0, ro_left} <= exp_p1; // RULE16
  wire start_std = xpw ? 1'b1 : align_ok;
  wire start_exp = (state == etl_pkg::ETL_WAIT) &&
    (var_s ? start_var : start_std);
  // pulse mode holds exposure open until the old readout drains
  wire pw_end = !pulse_lvl && (ro_left <= 24'h00_0001); // RULE18
  wire end_exp = (state == etl_pkg::ETL_EXPOSE) &&
    (xpw ? pw_end : (exp_left <= 24'h00_0001)); // RULE21
  wire pre_tick = pre == 6'(`ETL_CYC_US - 1);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cc1_q <= 1'b0;
      per_cnt <= 24'h00_0000;
      burst_left <= 16'h0000;
      trig_reject_o <= 1'b0;
    end else begin
      cc1_q <= cc1;
      if (ten || per_cnt == 24'h00_0000) begin
        per_cnt <= ten ? 24'h00_0000 : per_len - 24'h00_0001; // RULE7
      end else begin
        per_cnt <= per_cnt - 24'h00_0001;
      end
      if (!bm) begin
        burst_left <= 16'h0000;
      end else if (trig_ok) begin
        burst_left <= burst_lim; // RULE6
      end else if (burst_go) begin
        burst_left <= burst_left - 16'h0001;
      end
      trig_reject_o <= raw_trig && !trig_ok; // RULE12
    end
  end

  // frame sequencer
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state <= etl_pkg::ETL_IDLE;
      hold_left <= 21'h0_0000;
      pre <= 6'h00;
      wcnt <= 12'h000;
      seen_ro <= 1'b0;
      exp_left <= 24'h00_0000;
      exposure_o <= 1'b0;
    end else begin
      case (state)
        etl_pkg::ETL_IDLE: begin
          pre <= 6'h00;
          wcnt <= 12'h000;
          seen_ro <= 1'b0;
          hold_left <= hold;
          if (go) begin
            if (hold == 21'h0_0000) begin
              state <= etl_pkg::ETL_WAIT;
            end else begin
              state <= etl_pkg::ETL_HOLD; // RULE20
            end
          end
        end
        etl_pkg::ETL_HOLD: begin
          if (pre_tick) begin
            pre <= 6'h00;
            hold_left <= hold_left - 21'h0_0001; // RULE20
            if (hold_left == 21'h0_0001) begin
              state <= etl_pkg::ETL_WAIT;
            end
          end else begin
            pre <= pre + 6'h01;
          end
        end
        etl_pkg::ETL_WAIT: begin
          // counts restart while the old readout still runs
          if (ro_act) begin
            wcnt <= 12'h000;
            seen_ro <= 1'b1; // RULE15
          end else if (wcnt != 12'hFFF) begin
            wcnt <= wcnt + 12'h001; // RULE13
          end
          if (start_exp) begin
            state <= etl_pkg::ETL_EXPOSE;
            exp_left <= exp_len;
            exposure_o <= 1'b1;
          end
        end
        etl_pkg::ETL_EXPOSE: begin
          if (exp_left != 24'h00_0000) begin
            exp_left <= exp_left - 24'h00_0001;
          end
          if (end_exp) begin
            state <= etl_pkg::ETL_IDLE;
            exposure_o <= 1'b0;
          end
        end
        default: begin
          state <= etl_pkg::ETL_IDLE;
          exposure_o <= 1'b0;
        end
      endcase
    end
  end

  // readout: reload on exposure end overrides the last count
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ro_left <= 24'h00_0000;
      readout_o <= 1'b0;
    end else if (end_exp) begin
      ro_left <= ro_len; // RULE17
      readout_o <= ro_len != 24'h00_0000;
    end else if (ro_act) begin
      ro_left <= ro_left - 24'h00_0001;
      readout_o <= ro_left > 24'h00_0001;
    end else begin
      readout_o <= 1'b0;
    end
  end

  // read mux; all lines are inputs on this link
  wire [NL-1:0] dir_word = '0; // RULE5
  wire [31:0] stat_w = {24'h00_0000, burst_left != 16'h0000,
    readout_o, exposure_o, dir_word, lvl_now,
    lvl_now[lsel]}; // RULE1 RULE2

  always_comb begin
    if (addr_i == `ETL_A_CTRL) begin
      rd_mux = {19'h0_0000, ctrl};
    end else if (addr_i == `ETL_A_SETTLE) begin
      rd_mux = {16'h0000, settle};
    end else if (addr_i == `ETL_A_HOLD) begin
      rd_mux = {11'h000, hold};
    end else if (addr_i == `ETL_A_EXP) begin
      rd_mux = {8'h00, exp_len};
    end else if (addr_i == `ETL_A_PER) begin
      rd_mux = {8'h00, per_len};
    end else if (addr_i == `ETL_A_RO) begin
      rd_mux = {8'h00, ro_len};
    end else if (addr_i == `ETL_A_BURST) begin
      rd_mux = {16'h0000, burst_lim};
    end else if (addr_i == `ETL_A_LSEL) begin
      rd_mux = {31'h0000_0000, lsel};
    end else if (addr_i == `ETL_A_STAT) begin
      rd_mux = stat_w; // RULE1 RULE2
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
    end
  end
endmodule : etl_trigger_ctrl

// File: testbench/etl_asserts.sv
// port checker for the exposure trigger block
`timescale 1ns/1ps
module etl_asserts (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [5:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0] cc_line_i,
  input wire logic timer_one_done_event_i,
  input wire logic counter_one_done_event_i,
  input wire logic exposure_o,
  input wire logic readout_o,
  input wire logic trig_reject_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_exp_end;
    $fell(exposure_o);
  endsequence
  sequence s_stat_rd;
    rd_i && addr_i == 6'h20;
  endsequence
  a_ro_follows_exp: assert property (s_exp_end |-> readout_o)
    else $error("readout did not follow exposure end");
  a_dir_input: assert property (s_stat_rd |=> rdata_o[4:3] == 2'h0)
    else $error("line direction not input");
  a_line_pick: assert property (s_stat_rd |=>
    rdata_o[0] == rdata_o[1] || rdata_o[0] == rdata_o[2])
    else $error("selected level matches no line");
  a_stat_unused: assert property (s_stat_rd |=> rdata_o[31:8] == 24'h00_0000)
    else $error("status unused bits set");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data outside read slot");
  a_sw_reads_zero: assert property (rd_i && addr_i == 6'h24 |=> rdata_o == 0)
    else $error("software trigger reads nonzero");
  a_unmapped_zero: assert property (rd_i && addr_i > 6'h24 |=> rdata_o == 0)
    else $error("unmapped read nonzero");
  a_reject_pulse: assert property (trig_reject_o |=> !trig_reject_o)
    else $error("reject longer than one cycle");
endmodule : etl_asserts

// File: testbench/etl_grabber.sv
// frame grabber model driving the camera control lines
`timescale 1ns/1ps
module etl_grabber (
  input wire logic clock_i,
  input wire logic go_i,
  input wire logic [15:0] width_i,
  input wire logic cc2_i,
  output logic [1:0] cc_line_o
);
  logic [15:0] left = 16'h0000;
  // plain always: the declaration initialiser is a second writer of left
  always @(posedge clock_i) begin
    if (go_i) begin
      left <= width_i;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
    end
  end
  // cc1 high while a pulse is due; short widths test the filter
  assign cc_line_o = {cc2_i, left != 16'h0000};
endmodule : etl_grabber

// File: testbench/test_exposure_trigger_line_control.sv
// testbench for the exposure trigger block
`timescale 1ns/1ps
module test_exposure_trigger_line_control;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic tmr = 1'b0;
  logic cnt = 1'b0;
  logic gp = 1'b0;
  logic cc2 = 1'b0;
  logic [5:0] addr_i = 6'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic [31:0] rdata_o;
  logic [15:0] gw = 16'h0000;
  logic [1:0] cc_line;
  logic exposure_o;
  logic readout_o;
  logic trig_reject_o;
  int fails = 0;
  int n_compared = 0;
  int hi;
  int ups;
  int rej;
  int rds;
  int rup;
  etl_grabber fg (.clock_i(clock_i), .go_i(gp), .width_i(gw),
    .cc2_i(cc2), .cc_line_o(cc_line));
  etl_trigger_ctrl dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .cc_line_i(cc_line), .timer_one_done_event_i(tmr),
    .counter_one_done_event_i(cnt), .exposure_o(exposure_o),
    .readout_o(readout_o), .trig_reject_o(trig_reject_o));
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(logic [5:0] a, logic [31:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(logic [5:0] a, output logic [31:0] v);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd
  task automatic pulse(logic [15:0] w);
    @(posedge clock_i);
    gp <= 1'b1;
    gw <= w;
    @(posedge clock_i);
    gp <= 1'b0;
  endtask : pulse
  // sampled 1 ns after each edge so registered outputs have settled
  // the current cycle counts too, so an exposure launched at entry is seen
  task automatic watch(int lim);
    logic p;
    logic q;
    p = 1'b0;
    q = 1'b0;
    hi = 0;
    ups = 0;
    rej = 0;
    rds = 0;
    rup = 0;
    repeat (lim) begin
      #1;
      hi += (exposure_o === 1'b1);
      ups += (exposure_o === 1'b1 && p !== 1'b1);
      rej += (trig_reject_o === 1'b1);
      rds += (readout_o === 1'b1);
      rup += (readout_o === 1'b1 && q !== 1'b1);
      p = exposure_o;
      q = readout_o;
      @(posedge clock_i);
    end
  endtask : watch
  task automatic s_free;
    watch(4100);
    chk("free exposure cycles", 32'h0000_0FA0, hi);
    chk("free exposures", 1, ups);
    repeat (8100) @(posedge clock_i);
  endtask : s_free
  task automatic s_regs;
    logic [5:0] ra [8] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14,
      6'h18, 6'h28};
    logic [31:0] rv [8] = '{32'h0000_0000, 32'h0000_0028, 32'h0000_0000,
      32'h0000_0FA0, 32'h0000_9C40, 32'h0000_1F40, 32'h0000_0001,
      32'h0000_0000};
    logic [31:0] v;
    foreach (ra[i]) begin
      rd(ra[i], v);
      chk("reset value", rv[i], v);
    end
  endtask : s_regs
  task automatic s_sw;
    wr(6'h0C, 32'h0000_0002);
    wr(6'h14, 32'h0000_0003);
    wr(6'h04, 32'h0000_0005);
    wr(6'h00, 32'h0000_0003);
    wr(6'h24, 32'h0000_0001);
    wr(6'h24, 32'h0000_0001);
    watch(20);
    chk("sw exposures", 1, ups);
    chk("sw exposure cycles", 2, hi);
    chk("overlap off rejects", 1, rej);
    chk("sw readout cycles", 3, rds);
    @(posedge clock_i) tmr <= 1'b1;
    @(posedge clock_i) tmr <= 1'b0;
    watch(20);
    chk("timer under sw origin", 0, ups);
  endtask : s_sw
  task automatic s_origins;
    for (int o = 2; o < 4; o++) begin
      wr(6'h00, 32'h0000_0001 | 32'(o << 1));
      @(posedge clock_i);
      tmr <= (o == 2);
      cnt <= (o == 3);
      @(posedge clock_i);
      tmr <= 1'b0;
      cnt <= 1'b0;
      watch(20);
      chk("event origin exposures", 1, ups);
    end
  endtask : s_origins
  task automatic s_cc1;
    wr(6'h00, 32'h0000_0001);
    pulse(16'h0004);
    watch(30);
    chk("short pulse filtered", 0, ups);
    pulse(16'h000C);
    watch(40);
    chk("cc1 rise exposures", 1, ups);
    wr(6'h00, 32'h0000_0009);
    pulse(16'h001E);
    watch(20);
    chk("fall mode early", 0, ups);
    watch(40);
    chk("fall mode exposures", 1, ups);
  endtask : s_cc1
  task automatic s_lines;
    logic [31:0] v;
    wr(6'h1C, 32'h0000_0001);
    cc2 <= 1'b1;
    repeat (4) @(posedge clock_i);
    rd(6'h20, v);
    chk("line levels", 5'h05, v[4:0]);
    wr(6'h00, 32'h0000_0801);
    rd(6'h20, v);
    chk("flipped levels", 5'h00, v[4:0]);
  endtask : s_lines
  task automatic s_hold;
    logic [31:0] v;
    wr(6'h08, 32'h00FF_FFFF);
    rd(6'h08, v);
    chk("hold clamp", 32'h001E_8480, v);
    wr(6'h08, 32'h0000_0001);
    wr(6'h00, 32'h0000_0003);
    wr(6'h24, 32'h0000_0001);
    watch(30);
    chk("held early", 0, ups);
    watch(30);
    chk("held exposure", 1, ups);
    wr(6'h08, 32'h0000_0000);
  endtask : s_hold
  task automatic s_burst;
    wr(6'h18, 32'h0000_0003);
    wr(6'h00, 32'h0000_0203);
    wr(6'h24, 32'h0000_0001);
    watch(80);
    chk("burst frames", 3, ups);
  endtask : s_burst
  task automatic s_overlap;
    wr(6'h14, 32'h0000_0008);
    wr(6'h00, 32'h0000_0043);
    wr(6'h24, 32'h0000_0001);
    fork
      watch(30);
      begin
        repeat (4) @(posedge clock_i);
        wr(6'h24, 32'h0000_0001);
      end
    join
    chk("readout overlap rejects", 0, rej);
    chk("overlap exposures", 2, ups);
    chk("overlap exposure cycles", 4, hi);
    chk("overlap readout cycles", 16, rds);
    chk("overlap readout starts", 1, rup);
  endtask : s_overlap
  // second pulse ends well before the first readout drains
  task automatic s_pulse;
    wr(6'h14, 32'h0000_0028);
    wr(6'h00, 32'h0000_0141);
    pulse(16'h000A);
    fork
      watch(110);
      begin
        repeat (26) @(posedge clock_i);
        pulse(16'h000A);
      end
    join
    chk("pulse exposures", 2, ups);
    chk("pulse exposure cycles", 30, hi);
    chk("pulse readout cycles", 80, rds);
    chk("pulse readout starts", 1, rup);
  endtask : s_pulse
  task automatic s_variant;
    wr(6'h00, 32'h0000_1003);
    wr(6'h24, 32'h0000_0001);
    watch(128);
    chk("latency early", 0, ups);
    watch(20);
    chk("latency exposures", 1, ups);
  endtask : s_variant
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    forever #12.5 clock_i = ~clock_i;
  end
  initial begin
    repeat (8) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    s_free();
    s_regs();
    s_sw();
    s_origins();
    s_cc1();
    s_lines();
    s_hold();
    s_burst();
    s_overlap();
    s_pulse();
    s_variant();
    complete_run();
  end
  // whole run is near 13000 cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    fails++;
    complete_run();
  end
endmodule : test_exposure_trigger_line_control
bind etl_trigger_ctrl etl_asserts u_chk (.clock_i(clock_i),
  .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .cc_line_i(cc_line_i),
  .timer_one_done_event_i(timer_one_done_event_i),
  .counter_one_done_event_i(counter_one_done_event_i),
  .exposure_o(exposure_o), .readout_o(readout_o),
  .trig_reject_o(trig_reject_o));
